/* File: core/spfm_pkg.sv */
// Constants for the shared pin function mux: register map, field
// positions, reset values, bus answers and capture states.
// Assumes a 32-bit AXI4-Lite register bus and sixteen GPIO pins.
package spfm_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [4:0] REG_GPIO_ENABLE = 5'h00;
  localparam logic [4:0] REG_GPIO_DIRECTION = 5'h04;
  localparam logic [4:0] REG_GPIO_OUT_VALUE = 5'h08;
  localparam logic [4:0] REG_GPIO_IN_VALUE = 5'h0c;
  localparam logic [4:0] REG_STRAP_STATUS = 5'h10;

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [15:0] GPIO_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] GPIO_DIRECTION_RESET = 16'h0000;
  localparam logic [15:0] GPIO_OUT_VALUE_RESET = 16'h0000;
  localparam int GPIO_COUNT = 16;
  localparam int GPIO_DIV4_PIN = 1;
  localparam int GPIO_DIV6_PIN = 2;
  localparam int GPIO_SERIAL2_CLK_PIN = 8;
  localparam int GPIO_UPPER_LOW = 9;
  localparam int GPIO_UPPER_HIGH = 15;
  localparam int STRAP_BIT_HOST_32BIT = 0;
  localparam int STRAP_BIT_PCI_OWNS = 1;
  localparam int STRAP_BIT_CAPTURED = 2;
  localparam int HOST_STRAP_DATA_BIT = 5;
  localparam logic HOST_WIDTH_STRAP_32BIT = 1'b1;

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Strap capture sequence
  typedef enum logic [1:0] {
    CAP_SAMPLE = 2'b01,
    CAP_RUN = 2'b10
  } spfm_cap_state_t;

endpackage

/* File: core/spfm_pin_cell.sv */
// Registered two-source pin driver: source A wins over source B,
// with neither selected the pins float.
// Assumes the select inputs are already settled in the clock domain.
`timescale 1ns/1ps
module spfm_pin_cell #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic selA,
  input wire logic [W-1:0] aOut,
  input wire logic [W-1:0] aOe,
  input wire logic selB,
  input wire logic [W-1:0] bOut,
  input wire logic [W-1:0] bOe,
  output logic [W-1:0] pinOut,
  output logic [W-1:0] pinOe
);

  // Pin drive, floating under reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinOut <= '0;
      pinOe <= '0;
    end else if (selA) begin
      pinOut <= aOut;
      pinOe <= aOe;
    end else if (selB) begin
      pinOut <= bOut;
      pinOe <= bOe;
    end else begin
      pinOut <= '0;
      pinOe <= '0;
    end
  end

endmodule

/* File: core/spfm_shared_pin_mux.sv */
// Shared pin function mux: strap-owned host/PCI pins and
// software-owned GPIO pins, with an AXI4-Lite register slave.
// Assumes straps are steady until the first edge after rst falls and all inputs are
// synchronous to ref_clk.
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module spfm_shared_pin_mux #(
  parameter int HOST_W = 32,
  parameter int CTRL_W = 11,
  parameter int PCI_ONLY_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Strap level
  input wire logic pciEnableStrap,
  // Host data pins, also PCI address/data
  input wire logic [HOST_W-1:0] hostDataLinesIn,
  output logic [HOST_W-1:0] hostDataLinesOut,
  output logic [HOST_W-1:0] hostDataLinesOe,
  // Shared host control / PCI control pins
  input wire logic [CTRL_W-1:0] sharedCtrlIn,
  output logic [CTRL_W-1:0] sharedCtrlOut,
  output logic [CTRL_W-1:0] sharedCtrlOe,
  // PCI-only pins
  input wire logic [PCI_ONLY_W-1:0] pciOnlyIn,
  output logic [PCI_ONLY_W-1:0] pciOnlyOut,
  output logic [PCI_ONLY_W-1:0] pciOnlyOe,
  // GPIO pins
  input wire logic [15:0] gpioPinIn,
  output logic [15:0] gpioPinOut,
  output logic [15:0] gpioPinOe,
  // Host port core side
  input wire logic [HOST_W-1:0] hostCoreDataOut,
  input wire logic hostCoreDataOe,
  output logic [HOST_W-1:0] hostCoreDataIn,
  input wire logic [CTRL_W-1:0] hostCoreCtrlOut,
  input wire logic [CTRL_W-1:0] hostCoreCtrlOe,
  output logic [CTRL_W-1:0] hostCoreCtrlIn,
  output logic hostPort16bitMode,
  output logic hostPort32bitMode,
  // PCI core side
  input wire logic [HOST_W-1:0] pciCoreAdOut,
  input wire logic pciCoreAdOe,
  output logic [HOST_W-1:0] pciCoreAdIn,
  input wire logic [CTRL_W-1:0] pciCoreCtrlOut,
  input wire logic [CTRL_W-1:0] pciCoreCtrlOe,
  output logic [CTRL_W-1:0] pciCoreCtrlIn,
  input wire logic [PCI_ONLY_W-1:0] pciCoreOnlyOut,
  input wire logic [PCI_ONLY_W-1:0] pciCoreOnlyOe,
  output logic [PCI_ONLY_W-1:0] pciCoreOnlyIn,
  input wire logic [6:0] pciCoreUpperOut,
  input wire logic [6:0] pciCoreUpperOe,
  output logic [6:0] pciCoreUpperIn,
  output logic pciOwnsPins,
  // Clock sources and serial-2 clock sink
  input wire logic cpuDiv4ClockOut,
  input wire logic cpuDiv6ClockOut,
  output logic serial2ExternalClockIn
);

  localparam int HALF_W = HOST_W / 2;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (HOST_W != 32) begin : gBadHostWidth
    $error("HOST_W must be 32");
  end
  if (CTRL_W < 1 || PCI_ONLY_W < 1) begin : gBadGroupWidth
    $error("CTRL_W and PCI_ONLY_W must be at least 1");
  end

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  spfm_pkg::spfm_cap_state_t capState;
  logic hostWide;
  logic pciOwns;
  logic strapsCaught;
  logic hostOwns;

  // Sample once on the first edge after reset release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      capState <= spfm_pkg::CAP_SAMPLE;
      hostWide <= 1'b0;
      pciOwns <= 1'b0;
    end else begin
      unique case (capState)
        spfm_pkg::CAP_SAMPLE: begin
          hostWide <= hostDataLinesIn[spfm_pkg::HOST_STRAP_DATA_BIT] ==
                      spfm_pkg::HOST_WIDTH_STRAP_32BIT;
          pciOwns <= pciEnableStrap;
          capState <= spfm_pkg::CAP_RUN;
        end
        spfm_pkg::CAP_RUN: begin
          capState <= spfm_pkg::CAP_RUN;
        end
        default: begin
          capState <= spfm_pkg::CAP_SAMPLE;
        end
      endcase
    end
  end

  assign strapsCaught = (capState == spfm_pkg::CAP_RUN);
  assign hostOwns = strapsCaught && !pciOwns;

  // Mode flags for the cores
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hostPort16bitMode <= 1'b0;
      hostPort32bitMode <= 1'b0;
      pciOwnsPins <= 1'b0;
    end else begin
      hostPort16bitMode <= hostOwns && !hostWide;
      hostPort32bitMode <= hostOwns && hostWide;
      pciOwnsPins <= strapsCaught && pciOwns;
    end
  end

  // ----------------------------------------
  // Strap-owned pin drivers
  // ----------------------------------------
  logic pciSel;
  assign pciSel = strapsCaught && pciOwns;

  // Lower host data half: host or PCI, never both
  spfm_pin_cell #(.W(HALF_W)) uHostLow (
    .ref_clk(ref_clk),
    .rst(rst),
    .selA(hostOwns),
    .aOut(hostCoreDataOut[HALF_W-1:0]),
    .aOe({HALF_W{hostCoreDataOe}}),
    .selB(pciSel),
    .bOut(pciCoreAdOut[HALF_W-1:0]),
    .bOe({HALF_W{pciCoreAdOe}}),
    .pinOut(hostDataLinesOut[HALF_W-1:0]),
    .pinOe(hostDataLinesOe[HALF_W-1:0])
  );

  // Upper host data half: host only in 32-bit mode
  spfm_pin_cell #(.W(HOST_W - HALF_W)) uHostHigh (
    .ref_clk(ref_clk),
    .rst(rst),
    .selA(hostOwns && hostWide),
    .aOut(hostCoreDataOut[HOST_W-1:HALF_W]),
    .aOe({(HOST_W - HALF_W){hostCoreDataOe}}),
    .selB(pciSel),
    .bOut(pciCoreAdOut[HOST_W-1:HALF_W]),
    .bOe({(HOST_W - HALF_W){pciCoreAdOe}}),
    .pinOut(hostDataLinesOut[HOST_W-1:HALF_W]),
    .pinOe(hostDataLinesOe[HOST_W-1:HALF_W])
  );

  // Shared control pins
  spfm_pin_cell #(.W(CTRL_W)) uCtrl (
    .ref_clk(ref_clk),
    .rst(rst),
    .selA(hostOwns),
    .aOut(hostCoreCtrlOut),
    .aOe(hostCoreCtrlOe),
    .selB(pciSel),
    .bOut(pciCoreCtrlOut),
    .bOe(pciCoreCtrlOe),
    .pinOut(sharedCtrlOut),
    .pinOe(sharedCtrlOe)
  );

  // PCI-only pins float unless PCI owns them
  spfm_pin_cell #(.W(PCI_ONLY_W)) uPciOnly (
    .ref_clk(ref_clk),
    .rst(rst),
    .selA(pciSel),
    .aOut(pciCoreOnlyOut),
    .aOe(pciCoreOnlyOe),
    .selB(1'b0),
    .bOut('0),
    .bOe('0),
    .pinOut(pciOnlyOut),
    .pinOe(pciOnlyOe)
  );

  // Inputs reach only the owning core
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hostCoreDataIn <= '0;
      hostCoreCtrlIn <= '0;
      pciCoreAdIn <= '0;
      pciCoreCtrlIn <= '0;
      pciCoreOnlyIn <= '0;
    end else begin
      hostCoreDataIn[HALF_W-1:0] <= hostOwns ? hostDataLinesIn[HALF_W-1:0] : '0;
      hostCoreDataIn[HOST_W-1:HALF_W] <= (hostOwns && hostWide) ?
                                         hostDataLinesIn[HOST_W-1:HALF_W] : '0;
      hostCoreCtrlIn <= hostOwns ? sharedCtrlIn : '0;
      pciCoreAdIn <= pciSel ? hostDataLinesIn : '0;
      pciCoreCtrlIn <= pciSel ? sharedCtrlIn : '0;
      pciCoreOnlyIn <= pciSel ? pciOnlyIn : '0;
    end
  end

  // ----------------------------------------
  // GPIO registers and pin drivers
  // ----------------------------------------
  logic [15:0] gpioPinFunctionEnable;
  logic [15:0] gpioPinDirection;
  logic [15:0] gpioOutValue;
  logic [15:0] gpioInValue;
  logic [15:0] gpioAllowed;
  logic [15:0] altSel;
  logic [15:0] altOut;
  logic [15:0] altOe;

  // Alternate functions and GPIO permission per pin
  always_comb begin
    altSel = '0;
    altOut = '0;
    altOe = '0;
    gpioAllowed = '1;
    altSel[spfm_pkg::GPIO_DIV4_PIN] = 1'b1;
    altOut[spfm_pkg::GPIO_DIV4_PIN] = cpuDiv4ClockOut;
    altOe[spfm_pkg::GPIO_DIV4_PIN] = 1'b1;
    altSel[spfm_pkg::GPIO_DIV6_PIN] = 1'b1;
    altOut[spfm_pkg::GPIO_DIV6_PIN] = cpuDiv6ClockOut;
    altOe[spfm_pkg::GPIO_DIV6_PIN] = 1'b1;
    for (int i = spfm_pkg::GPIO_UPPER_LOW; i <= spfm_pkg::GPIO_UPPER_HIGH; i++) begin
      gpioAllowed[i] = hostOwns;
      altSel[i] = pciSel;
      altOut[i] = pciCoreUpperOut[i - spfm_pkg::GPIO_UPPER_LOW];
      altOe[i] = pciCoreUpperOe[i - spfm_pkg::GPIO_UPPER_LOW];
    end
  end

  // One driver cell per GPIO pin
  for (genvar g = 0; g < spfm_pkg::GPIO_COUNT; g++) begin : gGpio
    spfm_pin_cell #(.W(1)) uPin (
      .ref_clk(ref_clk),
      .rst(rst),
      .selA(gpioPinFunctionEnable[g] && gpioAllowed[g]),
      .aOut(gpioOutValue[g]),
      .aOe(gpioPinDirection[g]),
      .selB(altSel[g]),
      .bOut(altOut[g]),
      .bOe(altOe[g]),
      .pinOut(gpioPinOut[g]),
      .pinOe(gpioPinOe[g])
    );
  end

  // Pin level capture and alternate inputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gpioInValue <= '0;
      serial2ExternalClockIn <= 1'b0;
      pciCoreUpperIn <= '0;
    end else begin
      gpioInValue <= gpioPinIn;
      serial2ExternalClockIn <= gpioPinFunctionEnable[spfm_pkg::GPIO_SERIAL2_CLK_PIN] ?
                                1'b0 : gpioPinIn[spfm_pkg::GPIO_SERIAL2_CLK_PIN];
      pciCoreUpperIn <= pciSel ?
                        gpioPinIn[spfm_pkg::GPIO_UPPER_HIGH:spfm_pkg::GPIO_UPPER_LOW] : '0;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  logic awHeld;
  logic wHeld;
  logic [4:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic writeFire;
  logic writeHit;

  assign writeFire = awHeld && wHeld && !s_axi_bvalid;
  assign writeHit = awAddr == spfm_pkg::REG_GPIO_ENABLE ||
                    awAddr == spfm_pkg::REG_GPIO_DIRECTION ||
                    awAddr == spfm_pkg::REG_GPIO_OUT_VALUE;

  // Address and data are taken in either order
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (writeFire) begin
        awHeld <= 1'b0;
      end else if (!awHeld && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (writeFire) begin
        wHeld <= 1'b0;
      end else if (!wHeld && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= spfm_pkg::RESP_OKAY;
    end else if (writeFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= writeHit ? spfm_pkg::RESP_OKAY : spfm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers, byte lanes 0 and 1
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gpioPinFunctionEnable <= spfm_pkg::GPIO_ENABLE_RESET;
      gpioPinDirection <= spfm_pkg::GPIO_DIRECTION_RESET;
      gpioOutValue <= spfm_pkg::GPIO_OUT_VALUE_RESET;
    end else if (writeFire) begin
      for (int b = 0; b < 2; b++) begin
        if (wStrb[b]) begin
          unique case (awAddr)
            spfm_pkg::REG_GPIO_ENABLE: gpioPinFunctionEnable[b*8 +: 8] <= wData[b*8 +: 8];
            spfm_pkg::REG_GPIO_DIRECTION: gpioPinDirection[b*8 +: 8] <= wData[b*8 +: 8];
            spfm_pkg::REG_GPIO_OUT_VALUE: gpioOutValue[b*8 +: 8] <= wData[b*8 +: 8];
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  logic [31:0] readWord;
  logic readHit;

  // Read decode
  always_comb begin
    readWord = '0;
    readHit = 1'b1;
    unique case (s_axi_araddr)
      spfm_pkg::REG_GPIO_ENABLE: readWord[15:0] = gpioPinFunctionEnable;
      spfm_pkg::REG_GPIO_DIRECTION: readWord[15:0] = gpioPinDirection;
      spfm_pkg::REG_GPIO_OUT_VALUE: readWord[15:0] = gpioOutValue;
      spfm_pkg::REG_GPIO_IN_VALUE: readWord[15:0] = gpioInValue;
      spfm_pkg::REG_STRAP_STATUS: begin
        readWord[spfm_pkg::STRAP_BIT_HOST_32BIT] = hostWide;
        readWord[spfm_pkg::STRAP_BIT_PCI_OWNS] = pciOwns;
        readWord[spfm_pkg::STRAP_BIT_CAPTURED] = strapsCaught;
      end
      default: readHit = 1'b0;
    endcase
  end

  // Read handshake and data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= spfm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readWord;
      s_axi_rresp <= readHit ? spfm_pkg::RESP_OKAY : spfm_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

/* File: test/spfm_mux_asserts.sv */
// Checker for the shared pin mux, watching top-level ports only.
// Assumes it is bound into spfm_shared_pin_mux.
`timescale 1ns/1ps
module spfm_mux_asserts #(
  parameter int HOST_W = 32,
  parameter int PCI_ONLY_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic pciEnableStrap,
  input wire logic [HOST_W-1:0] hostDataLinesIn,
  input wire logic [HOST_W-1:0] hostDataLinesOut,
  input wire logic [HOST_W-1:0] hostDataLinesOe,
  input wire logic [PCI_ONLY_W-1:0] pciOnlyOe,
  input wire logic [6:0] pciCoreUpperIn,
  input wire logic [6:0] pciCoreUpperOe,
  input wire logic [15:0] gpioPinOut,
  input wire logic [15:0] gpioPinOe,
  input wire logic [HOST_W-1:0] hostCoreDataOut,
  input wire logic hostCoreDataOe,
  input wire logic hostPort16bitMode,
  input wire logic hostPort32bitMode,
  input wire logic pciOwnsPins,
  input wire logic cpuDiv4ClockOut,
  input wire logic cpuDiv6ClockOut
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [1:0] upCnt;
  logic wrSeen;
  // Edges since reset, and whether any write was taken
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upCnt <= 2'h0;
      wrSeen <= 1'b0;
    end else begin
      if (upCnt != 2'h3) upCnt <= upCnt + 2'h1;
      if (s_axi_awvalid && s_axi_awready) wrSeen <= 1'b1;
    end
  end
  // --------------------------------
  // Ownership checks
  // --------------------------------
  a_narrow_upper_float: assert property (
    hostPort16bitMode |-> hostDataLinesOe[HOST_W-1:16] == '0) else $error("upper lines driven");
  a_wide_all_lines: assert property (
    hostPort32bitMode && hostCoreDataOe |=> &hostDataLinesOe
      && hostDataLinesOut == $past(hostCoreDataOut)) else $error("wide lines wrong");
  a_owner_fixed: assert property (
    hostPort16bitMode || hostPort32bitMode || pciOwnsPins
      |=> $stable({pciOwnsPins, hostPort16bitMode, hostPort32bitMode})) else $error("owner moved");
  a_single_owner: assert property (
    upCnt[1] |-> $onehot({pciOwnsPins, hostPort16bitMode, hostPort32bitMode}))
    else $error("owner not unique");
  a_pci_only_float: assert property (
    !pciOwnsPins |-> pciOnlyOe == '0 && pciCoreUpperIn == '0) else $error("pci pins live");
  a_div4_default: assert property (
    upCnt == 2'h3 && !wrSeen |=> gpioPinOe[1] && gpioPinOut[1] == $past(cpuDiv4ClockOut))
    else $error("div4 clock missing");
  a_div6_default: assert property (
    upCnt == 2'h3 && !wrSeen |=> gpioPinOe[2] && gpioPinOut[2] == $past(cpuDiv6ClockOut))
    else $error("div6 clock missing");
  // Mode flags show the straps one edge after the capture edge
  a_strap_capture: assert property (
    upCnt == 2'h2 |-> pciOwnsPins == $past(pciEnableStrap, 2)
      && hostPort32bitMode == (!$past(pciEnableStrap, 2) && $past(hostDataLinesIn[5], 2)))
    else $error("strap capture wrong");
  a_float_at_capture: assert property (
    upCnt == 2'h1 |-> hostDataLinesOe == '0 && pciOnlyOe == '0) else $error("pins driven early");
  a_upper_pci_kept: assert property (
    pciOwnsPins && upCnt == 2'h3 |=> gpioPinOe[15:9] == $past(pciCoreUpperOe))
    else $error("upper pins left pci");
endmodule

bind spfm_shared_pin_mux spfm_mux_asserts #(.HOST_W(HOST_W), .PCI_ONLY_W(PCI_ONLY_W)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .pciEnableStrap(pciEnableStrap),
  .hostDataLinesIn(hostDataLinesIn), .hostDataLinesOut(hostDataLinesOut),
  .hostDataLinesOe(hostDataLinesOe), .pciOnlyOe(pciOnlyOe), .pciCoreUpperIn(pciCoreUpperIn),
  .pciCoreUpperOe(pciCoreUpperOe), .gpioPinOut(gpioPinOut), .gpioPinOe(gpioPinOe),
  .hostCoreDataOut(hostCoreDataOut), .hostCoreDataOe(hostCoreDataOe),
  .hostPort16bitMode(hostPort16bitMode), .hostPort32bitMode(hostPort32bitMode),
  .pciOwnsPins(pciOwnsPins), .cpuDiv4ClockOut(cpuDiv4ClockOut),
  .cpuDiv6ClockOut(cpuDiv6ClockOut)
);

/* File: test/spfm_strap_board.sv */
// Board straps and the host-side driver on the shared host data pins.
// Assumes straps hold from reset until three edges after it ends.
`timescale 1ns/1ps
module spfm_strap_board (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wideSel,
  input wire logic pciSel,
  input wire logic [31:0] hostDrive,
  input wire logic [31:0] devOut,
  input wire logic [31:0] devOe,
  output logic [31:0] hdLevel,
  output logic pciStrap
);
  logic [1:0] hold;
  // Width strap stays in force a little past reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) hold <= 2'h3;
    else if (hold != 2'h0) hold <= hold - 2'h1;
  end
  // Wire level: device first, then strap, then the host
  always_comb begin
    hdLevel = hostDrive;
    if (rst || hold != 2'h0) hdLevel[5] = wideSel;
    hdLevel = (devOe & devOut) | (~devOe & hdLevel);
  end
  // Resistor on the PCI strap; no boot address line is driven
  assign pciStrap = pciSel;
endmodule

/* File: test/spfm_shared_pin_mux_test.sv */
// Self-checking bench for the shared pin mux over its register bus.
// Assumes default widths and the strap board model beside the design.
`timescale 1ns/1ps
module spfm_shared_pin_mux_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] awAddr = 5'h00;
  logic [4:0] arAddr = 5'h00;
  logic [31:0] wData = 32'h0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic [31:0] pat = 32'h5a5a_a5a5;
  logic strapWide = 1'b0, strapPci = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, pciStrap, mode16, mode32, pciOwns, serial2;
  logic [1:0] bResp, rResp;
  logic [31:0] rData, hdLevel, hostOut, hostOe, m;
  logic [15:0] gpioOut, gpioOe;
  logic [7:0] pciOnlyOe;
  int err_count = 0, n_checks = 0, cyc = 0;

  // Clock at 4 ns
  initial forever #2 ref_clk = ~ref_clk;

  spfm_strap_board u_board (.ref_clk(ref_clk), .rst(rst), .wideSel(strapWide), .pciSel(strapPci),
    .hostDrive(~pat), .devOut(hostOut), .devOe(hostOe), .hdLevel(hdLevel), .pciStrap(pciStrap));

  spfm_shared_pin_mux u_dut (.ref_clk(ref_clk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'h3), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .pciEnableStrap(pciStrap), .hostDataLinesIn(hdLevel), .hostDataLinesOut(hostOut),
    .hostDataLinesOe(hostOe), .sharedCtrlIn(pat[10:0]), .sharedCtrlOut(), .sharedCtrlOe(),
    .pciOnlyIn(pat[7:0]), .pciOnlyOut(), .pciOnlyOe(pciOnlyOe), .gpioPinIn(pat[15:0]),
    .gpioPinOut(gpioOut), .gpioPinOe(gpioOe), .hostCoreDataOut(pat), .hostCoreDataOe(1'b1),
    .hostCoreDataIn(), .hostCoreCtrlOut(pat[10:0]), .hostCoreCtrlOe(pat[26:16]),
    .hostCoreCtrlIn(), .hostPort16bitMode(mode16), .hostPort32bitMode(mode32),
    .pciCoreAdOut(~pat), .pciCoreAdOe(1'b1), .pciCoreAdIn(), .pciCoreCtrlOut(pat[21:11]),
    .pciCoreCtrlOe(pat[10:0]), .pciCoreCtrlIn(), .pciCoreOnlyOut(pat[31:24]),
    .pciCoreOnlyOe(pat[7:0]), .pciCoreOnlyIn(), .pciCoreUpperOut(pat[30:24]),
    .pciCoreUpperOe(pat[22:16]), .pciCoreUpperIn(), .pciOwnsPins(pciOwns),
    .cpuDiv4ClockOut(pat[0]), .cpuDiv6ClockOut(pat[1]), .serial2ExternalClockIn(serial2));

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic results();
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic axiWr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awReady === 1'b1) awValid <= 1'b0;
      if (wReady === 1'b1) wValid <= 1'b0;
      t++;
    end while (bValid !== 1'b1 && t < 200);
    bReady <= 1'b0;
    chk("bvalid", {31'h0, bValid}, 32'h1);
    chk("bresp", {30'h0, bResp}, {30'h0, er});
    // Let an edge pass so a following call never re-raises bready in this step
    @(posedge ref_clk);
  endtask

  task automatic axiRd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    int t;
    t = 0;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arReady === 1'b1) arValid <= 1'b0;
      t++;
    end while (rValid !== 1'b1 && t < 200);
    rReady <= 1'b0;
    chk("rvalid", {31'h0, rValid}, 32'h1);
    chk("rdata", rData, e);
    chk("rresp", {30'h0, rResp}, {30'h0, er});
    // Let an edge pass so a following call never re-raises rready in this step
    @(posedge ref_clk);
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end

  // --------------------------------
  // Main sequence: one pass per strap setting
  // --------------------------------
  initial begin
    for (int k = 0; k < 3; k++) begin
      pat <= k == 0 ? 32'h5a5a_a5a5 : k == 1 ? 32'h3c3c_c3c3 : 32'h9696_6969;
      rst <= 1'b1;
      strapWide <= k == 1;
      strapPci <= k == 2;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      strapWide <= k != 1;
      strapPci <= k != 2;
      m = k == 0 ? 32'h0000_ffff : 32'hffff_ffff;
      axiRd(5'h10, {29'h0, 1'b1, k == 2, k == 1}, 2'h0);
      chk("owner", {pciOwns, mode32, mode16}, {k == 2, k == 1, k == 0});
      axiRd(5'h00, 32'h0, 2'h0);
      chk("clocks", {gpioOe[2:1], gpioOut[2:1]}, {2'h3, pat[1:0]});
      chk("hostOe", hostOe, m);
      chk("hostOut", hostOut & m, (k == 2 ? ~pat : pat) & m);
      chk("pciOnlyOe", pciOnlyOe, k == 2 ? pat[7:0] : 8'h00);
      axiWr(5'h00, 32'h0000_ffff, 2'h0);
      axiWr(5'h04, 32'h0000_80ff, 2'h0);
      axiWr(5'h08, 32'h0000_005a, 2'h0);
      repeat (2) @(posedge ref_clk);
      chk("gpioOe", gpioOe, k == 2 ? {pat[22:16], 9'h0ff} : 16'h80ff);
      chk("gpioOut", gpioOut[7:0], 8'h5a);
      chk("serial2", serial2, 1'b0);
      axiRd(5'h00, 32'h0000_ffff, 2'h0);
      axiRd(5'h0c, {16'h0, pat[15:0]}, 2'h0);
      axiWr(5'h00, 32'h0, 2'h0);
      repeat (2) @(posedge ref_clk);
      chk("reverted", {gpioOe[2:1], gpioOut[2:1]}, {2'h3, pat[1:0]});
      chk("serial2", serial2, pat[8]);
      axiWr(5'h10, 32'h0, 2'h2);
      axiRd(5'h14, 32'h0, 2'h2);
    end
    results();
  end
endmodule
